//--- rtl/lsd_cfg.svh
// Offsets, reset values, field positions and timing of the trim bank
`ifndef LSD_CFG_SVH
`define LSD_CFG_SVH

// Register indices; byte address is four times the index
`define LSD_IX_SW3_CUR       7'h56
`define LSD_IX_SW4_CUR       7'h57
`define LSD_IX_SW5_CUR       7'h58
`define LSD_IX_SW6_CUR       7'h59
`define LSD_IX_PERIOD        7'h5C
`define LSD_IX_SW_DELAY      7'h5D
`define LSD_IX_PULSE_WIDTH   7'h5E
`define LSD_IX_TRIM_CTL1     7'h60
`define LSD_IX_TRIM_CTL2     7'h61
`define LSD_IX_RING_MM_RES   7'h62
`define LSD_IX_TIP_MM_RES    7'h63
`define LSD_IX_DIFF_GAIN_RES 7'h64
`define LSD_IX_COMM_GAIN_RES 7'h65
`define LSD_IX_LIMIT_RES     7'h66
`define LSD_IX_MON_OFS_RES   7'h67
`define LSD_IX_CONV_OFS      7'h68
`define LSD_IX_OUT_OFS_RES   7'h69
`define LSD_IX_BAL_RES       7'h6A
`define LSD_IX_PEAK_RES      7'h6B

// Reset values
`define LSD_RST_PERIOD       8'hFF
`define LSD_RST_OFF_TIME     5'h14
`define LSD_RST_TRIM_CTL1    7'h1F
`define LSD_RST_TRIM_CTL2    5'h1F
`define LSD_RST_MM_RES       5'h10
`define LSD_RST_GAIN_RES     5'h11
`define LSD_RST_LIMIT_RES    4'h8
`define LSD_RST_MON_OFS_RES  8'h88
`define LSD_RST_CONV_OFS     4'h0
`define LSD_RST_OUT_OFS_RES  8'h00
`define LSD_RST_BAL_RES      6'h20
`define LSD_RST_PEAK_RES     4'h8

// Field positions
`define LSD_BIT_PERIOD_FIX   6
`define LSD_BIT_PEAK_START   7
`define LSD_BIT_FF_POL       5
`define LSD_BIT_FULL_START   6
`define LSD_BIT_SPEEDUP      5
`define LSD_OFF_TIME_ADD     8'h04

// Timing
`define LSD_CLK_PERIOD_NS    4
`define LSD_STEP_PS          61035
`define LSD_STEP_CYC         (`LSD_STEP_PS / (`LSD_CLK_PERIOD_NS * 1000))
`define LSD_SETTLE_LONG_MS   300
`define LSD_SETTLE_SHORT_MS  30
`define LSD_TRIM_STEP_CYC    1024

// Bus responses
`define LSD_RESP_OKAY        2'h0
`define LSD_RESP_SLVERR      2'h2

`endif

//--- rtl/lsd_pkg.sv
// Types shared by the line sense and converter trim bank
package lsd_pkg;
  typedef logic [6:0] lsd_index_t;
  typedef logic [7:0] lsd_byte_t;
  typedef logic [26:0] lsd_count_t;
  typedef enum logic [1:0] {
    LSD_TRIM_IDLE   = 2'b00,
    LSD_TRIM_SETTLE = 2'b01,
    LSD_TRIM_STEP   = 2'b10
  } lsd_trim_state_t;
endpackage : lsd_pkg

//--- rtl/lsd_regs.sv
// Line sense readbacks, converter PWM control and calibration register bank on AXI4-Lite
// What this block does
// - Two read-only 8-bit currents of switches three and four, 37.6 uA steps.
// - Two read-only 8-bit currents of switches five and six, 0.316 mA steps.
// - Converter period comes from an 8-bit code at 60 ns (15 clocks of 4 ns) per count.
// - Period code bit 6 reads one always; writes cannot change it.
// - Writing one to switch-delay bit 7 runs peak monitor trim; reads one while running.
// - Read-only bit 5 shows feed-forward polarity, fixed by device variant.
// - Minimum off time is (off-time code plus four) times 60 ns.
// - Read-only pulse-width code; pulse equals code minus off-time minus four steps.
// - Setting first control bit 6 runs whole-system trim; reads one until done.
// - Speedup bit selects 300 ms or 30 ms battery settling at trim start.
// - Five enable bits in first control register read one until their trim finishes.
// - Second control bits 4 and 3 enable monitor trims, read one until done.
// - Second control bit 2 trims voice output offset; stays one until done.
// - Second control bit 1 trims voice input offset; stays one until done.
// - Second control bit 0 trims longitudinal balance; stays one until done.
// - Ring, tip, differential and common gain results are writable 5-bit fields.
// - Monitor offsets are writable nibbles 7:4 and 3:0; limit result writable nibble.
// - Four writable offset trim bits in bits 3 down to 0.
// - Balance result 6 bits, output offset 8 bits, peak result 4 bits, writable.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "lsd_cfg.svh"

module lsd_regs #(
  parameter int SETTLE_LONG_CYC  = `LSD_SETTLE_LONG_MS * 1000000 / `LSD_CLK_PERIOD_NS,
  parameter int SETTLE_SHORT_CYC = `LSD_SETTLE_SHORT_MS * 1000000 / `LSD_CLK_PERIOD_NS,
  parameter bit FF_SAME_POLARITY = 1'b0
) (
  input  wire logic              REF_CLK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic [11:0]       S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  input  wire logic [31:0]       S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  input  wire logic [11:0]       S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  output logic [31:0]            S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN,
  input  wire lsd_pkg::lsd_byte_t SWITCH_THREE_CURRENT_IN,
  input  wire lsd_pkg::lsd_byte_t SWITCH_FOUR_CURRENT_IN,
  input  wire lsd_pkg::lsd_byte_t SWITCH_FIVE_CURRENT_IN,
  input  wire lsd_pkg::lsd_byte_t SWITCH_SIX_CURRENT_IN,
  input  wire lsd_pkg::lsd_byte_t DUTY_DEMAND_IN,
  output logic                   CONVERTER_DRIVE_PIN_OUT,
  output logic                   FEED_FORWARD_PIN_OUT,
  output logic                   TRIM_BUSY_OUT
);
  import lsd_pkg::*;
  localparam int STEP_CYC = (`LSD_STEP_CYC < 1) ? 1 : `LSD_STEP_CYC;
  localparam logic [3:0] STEP_LAST = 4'(STEP_CYC - 1);
  localparam lsd_count_t TRIM_LAST = 27'(`LSD_TRIM_STEP_CYC - 1);
  localparam lsd_count_t LONG_LAST = 27'(SETTLE_LONG_CYC - 1);
  localparam lsd_count_t SHORT_LAST = 27'(SETTLE_SHORT_CYC - 1);
  ////////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers
  // Multi-bit samples are slowly varying; a torn current sample lasts one read, a torn duty demand one PWM period
  logic [39:0] pin_meta_q;
  logic [39:0] pin_sync_q;

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_meta_q <= 40'h00_0000_0000;
      pin_sync_q <= 40'h00_0000_0000;
    end else begin
      pin_meta_q <= {DUTY_DEMAND_IN, SWITCH_SIX_CURRENT_IN, SWITCH_FIVE_CURRENT_IN,
                     SWITCH_FOUR_CURRENT_IN, SWITCH_THREE_CURRENT_IN};
      pin_sync_q <= pin_meta_q;
    end
  end
  wire lsd_byte_t sw3_cur = pin_sync_q[7:0];
  wire lsd_byte_t sw4_cur = pin_sync_q[15:8];
  wire lsd_byte_t sw5_cur = pin_sync_q[23:16];
  wire lsd_byte_t sw6_cur = pin_sync_q[31:24];
  wire lsd_byte_t demand  = pin_sync_q[39:32];
  ////////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] period_q;
  logic [4:0] off_time_q;
  logic       peak_busy_q;
  logic [6:0] trim_ctl1_q;
  logic [4:0] trim_ctl2_q;
  logic [4:0] ring_mm_q;
  logic [4:0] tip_mm_q;
  logic [4:0] diff_gain_q;
  logic [4:0] comm_gain_q;
  logic [3:0] limit_q;
  logic [7:0] mon_ofs_q;
  logic [3:0] conv_ofs_q;
  logic [7:0] out_ofs_q;
  logic [5:0] bal_q;
  logic [3:0] peak_res_q;
  logic [7:0] pulse_width_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Read decode
  function automatic logic [8:0] read_word(input lsd_index_t ix);
    case (ix)
      `LSD_IX_SW3_CUR:       read_word = {1'b1, sw3_cur};
      `LSD_IX_SW4_CUR:       read_word = {1'b1, sw4_cur};
      `LSD_IX_SW5_CUR:       read_word = {1'b1, sw5_cur};
      `LSD_IX_SW6_CUR:       read_word = {1'b1, sw6_cur};
      `LSD_IX_PERIOD:        read_word = {1'b1, period_q};
      `LSD_IX_SW_DELAY:      read_word = {1'b1, peak_busy_q, 1'b0, FF_SAME_POLARITY, off_time_q};
      `LSD_IX_PULSE_WIDTH:   read_word = {1'b1, pulse_width_q};
      `LSD_IX_TRIM_CTL1:     read_word = {2'b10, trim_ctl1_q};
      `LSD_IX_TRIM_CTL2:     read_word = {4'h8, trim_ctl2_q};
      `LSD_IX_RING_MM_RES:   read_word = {4'h8, ring_mm_q};
      `LSD_IX_TIP_MM_RES:    read_word = {4'h8, tip_mm_q};
      `LSD_IX_DIFF_GAIN_RES: read_word = {4'h8, diff_gain_q};
      `LSD_IX_COMM_GAIN_RES: read_word = {4'h8, comm_gain_q};
      `LSD_IX_LIMIT_RES:     read_word = {5'h10, limit_q};
      `LSD_IX_MON_OFS_RES:   read_word = {1'b1, mon_ofs_q};
      `LSD_IX_CONV_OFS:      read_word = {5'h10, conv_ofs_q};
      `LSD_IX_OUT_OFS_RES:   read_word = {1'b1, out_ofs_q};
      `LSD_IX_BAL_RES:       read_word = {3'h4, bal_q};
      `LSD_IX_PEAK_RES:      read_word = {5'h10, peak_res_q};
      default:               read_word = 9'h000;
    endcase
  endfunction : read_word
  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic       awready_q;
  logic       wready_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       aw_held_q;
  logic       w_held_q;
  logic [11:0] aw_addr_q;
  lsd_byte_t  w_byte_q;
  logic       w_lane0_q;
  wire        aw_take   = S_AXI_AWVALID_IN & awready_q;
  wire        w_take    = S_AXI_WVALID_IN & wready_q;
  wire        wr_fire   = aw_held_q & w_held_q & ~bvalid_q;
  wire        aw_held_d = aw_take | (aw_held_q & ~wr_fire);
  wire        w_held_d  = w_take | (w_held_q & ~wr_fire);
  wire        bvalid_d  = wr_fire | (bvalid_q & ~S_AXI_BREADY_IN);
  wire lsd_index_t wr_ix = aw_addr_q[8:2];
  logic [8:0] wr_word;
  always_comb wr_word = read_word(wr_ix);
  wire        wr_mapped = (aw_addr_q[11:9] == 3'h0) & wr_word[8];
  wire        wr_en     = wr_fire & wr_mapped & w_lane0_q;
  wire lsd_byte_t wd    = w_byte_q;
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `LSD_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_byte_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      awready_q <= ~aw_held_d & ~bvalid_d;
      wready_q  <= ~w_held_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      if (aw_take) aw_addr_q <= S_AXI_AWADDR_IN;
      if (w_take) begin
        w_byte_q  <= S_AXI_WDATA_IN[7:0];
        w_lane0_q <= S_AXI_WSTRB_IN[0];
      end
      if (wr_fire) bresp_q <= wr_mapped ? `LSD_RESP_OKAY : `LSD_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  lsd_byte_t   rdata_q;
  wire        ar_take  = S_AXI_ARVALID_IN & arready_q;
  wire        rvalid_d = ar_take | (rvalid_q & ~S_AXI_RREADY_IN);
  logic [8:0] rd_word;
  always_comb rd_word = read_word(S_AXI_ARADDR_IN[8:2]);
  wire        rd_hit   = (S_AXI_ARADDR_IN[11:9] == 3'h0) & rd_word[8];
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `LSD_RESP_OKAY;
      rdata_q   <= 8'h00;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word[7:0];
        rresp_q <= rd_hit ? `LSD_RESP_OKAY : `LSD_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer
  // Pending order: first control bits 4..0, then second control bits 4..0
  lsd_trim_state_t trim_state_q;
  lsd_count_t      trim_cnt_q;
  logic [3:0]      trim_cur_q;

  wire [9:0] pending = {trim_ctl2_q[0], trim_ctl2_q[1], trim_ctl2_q[2], trim_ctl2_q[3], trim_ctl2_q[4],
                        trim_ctl1_q[0], trim_ctl1_q[1], trim_ctl1_q[2], trim_ctl1_q[3], trim_ctl1_q[4]};
  function automatic logic [4:0] first_pending(input logic [9:0] p);
    first_pending = 5'h00;
    for (int i = 9; i >= 0; i--) begin
      if (p[i]) first_pending = {1'b1, 4'(i)};
    end
  endfunction : first_pending
  wire [4:0] next_pick   = first_pending(pending);
  wire [4:0] voice_pick  = first_pending({wd[0], wd[1], wd[2], 7'h00});
  wire       full_start  = wr_en & (wr_ix == `LSD_IX_TRIM_CTL1) & wd[`LSD_BIT_FULL_START];
  wire       voice_start = wr_en & (wr_ix == `LSD_IX_TRIM_CTL2) & (wd[2:0] != 3'h0);
  wire       trim_idle   = (trim_state_q == LSD_TRIM_IDLE);
  wire       count_done  = (trim_cnt_q == 27'h0000000);
  wire       step_done   = (trim_state_q == LSD_TRIM_STEP) & count_done;
  wire [9:0] done_vec    = step_done ? (10'h001 << trim_cur_q) : 10'h000;
  wire [4:0] done1       = {done_vec[0], done_vec[1], done_vec[2], done_vec[3], done_vec[4]};
  wire [4:0] done2       = {done_vec[5], done_vec[6], done_vec[7], done_vec[8], done_vec[9]};
  wire       seq_finish  = step_done & ~|(pending & ~done_vec);
  wire [4:0] rest_pick   = first_pending(pending & ~done_vec);
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      trim_state_q <= LSD_TRIM_IDLE;
      trim_cnt_q   <= 27'h0000000;
      trim_cur_q   <= 4'h0;
    end else begin
      case (trim_state_q)
        LSD_TRIM_IDLE: begin
          if (full_start) begin
            trim_state_q <= LSD_TRIM_SETTLE;
            trim_cnt_q   <= wd[`LSD_BIT_SPEEDUP] ? SHORT_LAST : LONG_LAST;
          end else if (voice_start) begin
            trim_state_q <= LSD_TRIM_STEP;
            trim_cnt_q   <= TRIM_LAST;
            trim_cur_q   <= voice_pick[3:0];
          end
        end
        LSD_TRIM_SETTLE: begin
          if (!count_done) begin
            trim_cnt_q <= trim_cnt_q - 27'h0000001;
          end else if (next_pick[4]) begin
            trim_state_q <= LSD_TRIM_STEP;
            trim_cnt_q   <= TRIM_LAST;
            trim_cur_q   <= next_pick[3:0];
          end else begin
            trim_state_q <= LSD_TRIM_IDLE;
          end
        end
        LSD_TRIM_STEP: begin
          if (!count_done) begin
            trim_cnt_q <= trim_cnt_q - 27'h0000001;
          end else if (seq_finish) begin
            trim_state_q <= LSD_TRIM_IDLE;
          end else begin
            trim_cnt_q <= TRIM_LAST;
            trim_cur_q <= rest_pick[3:0];
          end
        end
        default: trim_state_q <= LSD_TRIM_IDLE;
      endcase
    end
  end

  // Peak monitor trim runs on its own timer, alongside the main sequence
  lsd_count_t peak_cnt_q;
  wire        peak_start = wr_en & (wr_ix == `LSD_IX_SW_DELAY) & wd[`LSD_BIT_PEAK_START];
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      peak_busy_q <= 1'b0;
      peak_cnt_q  <= 27'h0000000;
    end else if (peak_start) begin
      peak_busy_q <= 1'b1;
      peak_cnt_q  <= TRIM_LAST;
    end else if (peak_busy_q) begin
      peak_cnt_q  <= peak_cnt_q - 27'h0000001;
      peak_busy_q <= (peak_cnt_q != 27'h0000000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software-written registers; a write in the same cycle as a hardware clear wins
  wire full_clear = (trim_state_q == LSD_TRIM_SETTLE) & count_done & ~next_pick[4] | seq_finish;

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      period_q    <= `LSD_RST_PERIOD;
      off_time_q  <= `LSD_RST_OFF_TIME;
      trim_ctl1_q <= `LSD_RST_TRIM_CTL1;
      trim_ctl2_q <= `LSD_RST_TRIM_CTL2;
      ring_mm_q   <= `LSD_RST_MM_RES;
      tip_mm_q    <= `LSD_RST_MM_RES;
      diff_gain_q <= `LSD_RST_GAIN_RES;
      comm_gain_q <= `LSD_RST_GAIN_RES;
      limit_q     <= `LSD_RST_LIMIT_RES;
      mon_ofs_q   <= `LSD_RST_MON_OFS_RES;
      conv_ofs_q  <= `LSD_RST_CONV_OFS;
      out_ofs_q   <= `LSD_RST_OUT_OFS_RES;
      bal_q       <= `LSD_RST_BAL_RES;
      peak_res_q  <= `LSD_RST_PEAK_RES;
    end else begin
      trim_ctl1_q <= {trim_ctl1_q[6] & ~full_clear, trim_ctl1_q[5], trim_ctl1_q[4:0] & ~done1};
      trim_ctl2_q <= trim_ctl2_q & ~done2;
      if (wr_en) begin
        case (wr_ix)
          `LSD_IX_PERIOD:        period_q    <= {wd[7], 1'b1, wd[5:0]};
          `LSD_IX_SW_DELAY:      off_time_q  <= wd[4:0];
          `LSD_IX_TRIM_CTL1:     trim_ctl1_q <= wd[6:0];
          `LSD_IX_TRIM_CTL2:     trim_ctl2_q <= wd[4:0];
          `LSD_IX_RING_MM_RES:   ring_mm_q   <= wd[4:0];
          `LSD_IX_TIP_MM_RES:    tip_mm_q    <= wd[4:0];
          `LSD_IX_DIFF_GAIN_RES: diff_gain_q <= wd[4:0];
          `LSD_IX_COMM_GAIN_RES: comm_gain_q <= wd[4:0];
          `LSD_IX_LIMIT_RES:     limit_q     <= wd[3:0];
          `LSD_IX_MON_OFS_RES:   mon_ofs_q   <= wd;
          `LSD_IX_CONV_OFS:      conv_ofs_q  <= wd[3:0];
          `LSD_IX_OUT_OFS_RES:   out_ofs_q   <= wd;
          `LSD_IX_BAL_RES:       bal_q       <= wd[5:0];
          `LSD_IX_PEAK_RES:      peak_res_q  <= wd[3:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter PWM
  // Codes are sampled only at a period boundary so a write never cuts a pulse short
  logic [3:0] step_cnt_q;
  lsd_byte_t  pos_q;
  lsd_byte_t  per_act_q;
  lsd_byte_t  on_ticks_q;
  logic       drive_q;
  logic       ff_q;
  wire       step_tick  = (step_cnt_q == STEP_LAST);
  wire       period_end = step_tick & (pos_q >= per_act_q - 8'h01);
  wire lsd_byte_t off_min  = {3'h0, off_time_q} + `LSD_OFF_TIME_ADD;
  wire lsd_byte_t on_limit = period_q - off_min;
  wire lsd_byte_t on_next  = (demand < on_limit) ? demand : on_limit;
  wire       drive_d    = period_end ? (on_next != 8'h00) : (pos_q + 8'h01 < on_ticks_q) | ~step_tick & drive_q;
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      step_cnt_q    <= 4'h0;
      pos_q         <= 8'h00;
      per_act_q     <= `LSD_RST_PERIOD;
      on_ticks_q    <= 8'h00;
      pulse_width_q <= 8'h00;
      drive_q       <= 1'b0;
      ff_q          <= 1'b0;
    end else begin
      step_cnt_q <= step_tick ? 4'h0 : step_cnt_q + 4'h1;
      if (period_end) begin
        pos_q         <= 8'h00;
        per_act_q     <= period_q;
        on_ticks_q    <= on_next;
        pulse_width_q <= on_next + off_min;
      end else if (step_tick) begin
        pos_q <= pos_q + 8'h01;
      end
      drive_q <= drive_d;
      ff_q    <= FF_SAME_POLARITY ? drive_d : ~drive_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic busy_q;
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) busy_q <= 1'b0;
    else busy_q <= ~trim_idle | peak_busy_q;
  end

  assign S_AXI_AWREADY_OUT       = awready_q;
  assign S_AXI_WREADY_OUT        = wready_q;
  assign S_AXI_BVALID_OUT        = bvalid_q;
  assign S_AXI_BRESP_OUT         = bresp_q;
  assign S_AXI_ARREADY_OUT       = arready_q;
  assign S_AXI_RVALID_OUT        = rvalid_q;
  assign S_AXI_RRESP_OUT         = rresp_q;
  assign S_AXI_RDATA_OUT         = {24'h000000, rdata_q};
  assign CONVERTER_DRIVE_PIN_OUT = drive_q;
  assign FEED_FORWARD_PIN_OUT    = ff_q;
  assign TRIM_BUSY_OUT           = busy_q;

endmodule : lsd_regs

//--- sim/lsd_regs_props.sv
// Bus and calibration timing checks for the trim register bank
`timescale 1ns/1ps
`include "lsd_cfg.svh"
module lsd_regs_props (
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic [11:0] S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  input  wire logic        S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  input  wire logic        S_AXI_WREADY_OUT,
  input  wire logic        S_AXI_BVALID_OUT,
  input  wire logic [11:0] S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  input  wire logic        S_AXI_ARREADY_OUT,
  input  wire logic [31:0] S_AXI_RDATA_OUT,
  input  wire logic        S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic        CONVERTER_DRIVE_PIN_OUT,
  input  wire logic        FEED_FORWARD_PIN_OUT,
  input  wire logic        TRIM_BUSY_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic [6:0] rd_ix_q;
  wire  [6:0] wr_ix = S_AXI_AWADDR_IN[8:2];
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) rd_ix_q <= 7'h00;
    else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) rd_ix_q <= S_AXI_ARADDR_IN[8:2];
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence wr_take_s;
    S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT && S_AXI_WSTRB_IN[0];
  endsequence
  // Busy must come quickly and then last well past a single sequencer tick
  sequence busy_soon_s;
    ##[1:4] TRIM_BUSY_OUT ##1 TRIM_BUSY_OUT[*8];
  endsequence
  full_start_a: assert property (wr_take_s ##0 (wr_ix == `LSD_IX_TRIM_CTL1 && S_AXI_WDATA_IN[6]) |-> busy_soon_s)
    else $error("full trim start did not raise busy");
  peak_start_a: assert property (wr_take_s ##0 (wr_ix == `LSD_IX_SW_DELAY && S_AXI_WDATA_IN[7]) |-> busy_soon_s)
    else $error("peak trim start did not raise busy");
  voice_start_a: assert property (wr_take_s ##0 (wr_ix == `LSD_IX_TRIM_CTL2 && !TRIM_BUSY_OUT && |S_AXI_WDATA_IN[2:0])
    |-> busy_soon_s)
    else $error("offset trim start did not raise busy");
  write_answer_a: assert property (wr_take_s |-> ##[1:2] S_AXI_BVALID_OUT)
    else $error("write response missing");
  read_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("read data not held");
  upper_zero_a: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  period_fix_a: assert property (S_AXI_RVALID_OUT && rd_ix_q == `LSD_IX_PERIOD |-> S_AXI_RDATA_OUT[6])
    else $error("period bit six reads zero");
  delay_rsvd_a: assert property (S_AXI_RVALID_OUT && rd_ix_q == `LSD_IX_SW_DELAY |-> S_AXI_RDATA_OUT[6:5] == 2'h0)
    else $error("switch delay fixed bits wrong");
  ff_polarity_a: assert property ($past(RST_N_IN) |-> FEED_FORWARD_PIN_OUT == !CONVERTER_DRIVE_PIN_OUT)
    else $error("feed forward polarity wrong");
endmodule : lsd_regs_props

//--- sim/tb_lsd_regs.sv
// Self-checking bench for the trim register bank over AXI4-Lite
`timescale 1ns/1ps
`include "lsd_cfg.svh"
module tb_lsd_regs;
  import lsd_pkg::*;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  wire         awready, wready, bvalid, arready, rvalid, drive, ff, busy;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  lsd_byte_t   cur3 = 8'h12, cur4 = 8'h34, cur5 = 8'h56, cur6 = 8'hFF, duty = 8'h10;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  lsd_byte_t   rrst [15] = '{8'hFF, 8'h14, 8'h00, 8'h1F, 8'h1F, 8'h10, 8'h10, 8'h11, 8'h11, 8'h08, 8'h88, 8'h00,
                             8'h00, 8'h20, 8'h08};
  lsd_byte_t   msk  [10] = '{8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h3F, 8'h0F};
  lsd_byte_t   d;
  logic [1:0]  r;

  always #2 clk = ~clk;

  // Short settle counts keep the calibration runs brief
  lsd_regs #(.SETTLE_LONG_CYC(40), .SETTLE_SHORT_CYC(20)) i_dut (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .SWITCH_THREE_CURRENT_IN(cur3),
    .SWITCH_FOUR_CURRENT_IN(cur4), .SWITCH_FIVE_CURRENT_IN(cur5), .SWITCH_SIX_CURRENT_IN(cur6),
    .DUTY_DEMAND_IN(duty), .CONVERTER_DRIVE_PIN_OUT(drive), .FEED_FORWARD_PIN_OUT(ff), .TRIM_BUSY_OUT(busy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_reg(input string what, input lsd_byte_t exp, input lsd_byte_t got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s response expected %h seen %h", what, exp, got);
    end
  endtask : chk_resp

  // Address and data offered together, each released once taken
  task automatic wr(input lsd_index_t ix, input lsd_byte_t v, input logic [3:0] st = 4'h1,
                    input logic [1:0] er = `LSD_RESP_OKAY);
    bit aw_ok, w_ok;
    @(posedge clk);
    aw_ok = 0;
    w_ok = 0;
    awaddr <= {3'h0, ix, 2'h0};
    wdata <= {24'h000000, v};
    wstrb <= st;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'h1) begin aw_ok = 1; awvalid <= 1'h0; end
      if (!w_ok && wready === 1'h1) begin w_ok = 1; wvalid <= 1'h0; end
    end
    while (bvalid !== 1'h1) @(posedge clk);
    chk_resp("write", er, bresp);
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input lsd_index_t ix, output lsd_byte_t v, output logic [1:0] rs);
    @(posedge clk);
    araddr <= {3'h0, ix, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    v = rdata[7:0];
    rs = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic rdchk(input lsd_index_t ix, input lsd_byte_t exp);
    lsd_byte_t v;
    logic [1:0] rs;
    rd(ix, v, rs);
    chk_reg($sformatf("reg %h", ix), exp, v);
    chk_resp("read", `LSD_RESP_OKAY, rs);
  endtask : rdchk

  // Bounded polling while hardware clears self-clearing bits
  task automatic poll(input lsd_index_t ix, input lsd_byte_t m, input lsd_byte_t exp);
    lsd_byte_t v;
    logic [1:0] rs;
    int k = 0;
    do begin rd(ix, v, rs); k++; end while ((v & m) != 8'h00 && k < 3000);
    chk_reg($sformatf("poll %h", ix), exp, v);
  endtask : poll

  task automatic conclude();
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 15; i++) rdchk(7'(i < 3 ? 8'h5C + i : 8'h5D + i), rrst[i]);
    for (int i = 0; i < 10; i++) begin
      wr(7'(8'h62 + i), 8'hFF);
      rdchk(7'(8'h62 + i), msk[i]);
      wr(7'(8'h62 + i), 8'h00);
      rdchk(7'(8'h62 + i), 8'h00);
    end
    wr(7'h62, 8'h05, 4'h0);
    rdchk(7'h62, 8'h00);
    wr(`LSD_IX_PERIOD, 8'h00);
    rdchk(`LSD_IX_PERIOD, 8'h40);
    wr(`LSD_IX_PERIOD, 8'h80);
    rdchk(`LSD_IX_PERIOD, 8'hC0);
    wr(`LSD_IX_PERIOD, 8'hFF);
    wr(`LSD_IX_SW3_CUR, 8'hAA);
    rdchk(`LSD_IX_SW3_CUR, cur3);
    rdchk(`LSD_IX_SW4_CUR, cur4);
    rdchk(`LSD_IX_SW5_CUR, cur5);
    rdchk(`LSD_IX_SW6_CUR, cur6);
    rd(7'h5A, d, r);
    chk_resp("unmapped", `LSD_RESP_SLVERR, r);
    chk_reg("unmapped", 8'h00, d);
    wr(7'h5F, 8'h01, 4'h1, `LSD_RESP_SLVERR);
    wr(`LSD_IX_SW_DELAY, 8'h43);
    rdchk(`LSD_IX_SW_DELAY, 8'h03);
    // Two full periods at code FF so the new off time is in use
    repeat (8000) @(posedge clk);
    rdchk(`LSD_IX_PULSE_WIDTH, 8'h17);
    wr(`LSD_IX_SW_DELAY, 8'h83);
    rdchk(`LSD_IX_SW_DELAY, 8'h83);
    poll(`LSD_IX_SW_DELAY, 8'h80, 8'h03);
    wr(`LSD_IX_TRIM_CTL2, 8'h00);
    wr(`LSD_IX_TRIM_CTL1, 8'h61);
    rdchk(`LSD_IX_TRIM_CTL1, 8'h61);
    chk_reg("busy", 8'h01, {7'h00, busy});
    poll(`LSD_IX_TRIM_CTL1, 8'h41, 8'h20);
    wr(`LSD_IX_TRIM_CTL2, 8'h1F);
    rdchk(`LSD_IX_TRIM_CTL2, 8'h1F);
    poll(`LSD_IX_TRIM_CTL2, 8'h1F, 8'h00);
    wr(`LSD_IX_TRIM_CTL1, 8'h40);
    poll(`LSD_IX_TRIM_CTL1, 8'h40, 8'h00);
    repeat (4) @(posedge clk);
    chk_reg("busy", 8'h00, {7'h00, busy});
    conclude();
  end
endmodule : tb_lsd_regs

bind lsd_regs lsd_regs_props i_props (.*);
